/* src/chan_cmd_pkg.sv */
// package: register map, command codes, timing constants and carriers for channel command block
package chan_cmd_pkg;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_CHAN_SELECT  = 8'h00;
   localparam logic [7:0] OFF_CHAN_CMD     = 8'h04;
   localparam logic [7:0] OFF_FW_REV       = 8'h08;
   localparam logic [7:0] OFF_PRESCALE     = 8'h0C;
   localparam logic [7:0] OFF_RX_TIMEOUT   = 8'h10;
   localparam logic [7:0] OFF_TX_CLK_OPT   = 8'h14;
   localparam logic [7:0] OFF_TX_BAUD      = 8'h18;
   localparam logic [7:0] OFF_RX_CLK_OPT   = 8'h1C;
   localparam logic [7:0] OFF_RX_BAUD      = 8'h20;
   localparam logic [7:0] OFF_CHAR_FORMAT  = 8'h24;
   localparam logic [7:0] OFF_FLOW_OPT     = 8'h28;
   localparam logic [7:0] OFF_SPECIAL_OPT  = 8'h2C;
   localparam logic [7:0] OFF_INPUT_OPT    = 8'h30;
   localparam logic [7:0] OFF_SVC_ENABLE   = 8'h34;
   localparam logic [7:0] OFF_CHAN_STATUS  = 8'h38;

   // ------------------------------------------------------------
   // command codes and field positions
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_GLOBAL_RESET = 8'h81;
   localparam logic [7:0] CMD_OPTS_CHANGED = 8'h4E;
   localparam logic [7:0] CMD_RXTX_ENABLE  = 8'h1A;
   localparam logic [7:0] CMD_NONE         = 8'h00;
   localparam logic [1:0] CHAN_SERIAL_A    = 2'h2;
   localparam logic [1:0] CHAN_SERIAL_B    = 2'h3;
   localparam int         CHAR_PARITY_BIT  = 5;
   localparam int         CHAR_STOP_BIT    = 3;
   localparam int         CHAR_LEN_LSB     = 0;
   localparam int         FLOW_INBAND_BIT  = 6;
   localparam int         SPC_TRANSP_BIT   = 5;
   localparam int         SPC_DET2_BIT     = 4;
   localparam int         SPC_DET1_BIT     = 3;
   localparam int         SPC_THRESH_LSB   = 0;
   localparam int         STRIP_BIT        = 7;
   localparam int         SVC_RX_BIT       = 4;
   localparam int         SVC_TX_BIT       = 2;
   localparam logic [7:0] RESET_BYTE       = 8'h00;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int         CLK_MHZ          = 125;
   localparam int         INIT_MAX_US      = 500;
   localparam int         INIT_MAX_CYC     = INIT_MAX_US * CLK_MHZ;
   localparam int         INIT_CLEAR_CYC   = 16;
   localparam logic [8:0] FIXED_PRESCALE_M1 = 9'h1FF;

   // ------------------------------------------------------------
   // per-channel option set and applied configuration
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] rx_timeout;
      logic [7:0] tx_clk_opt;
      logic [7:0] tx_baud;
      logic [7:0] rx_clk_opt;
      logic [7:0] rx_baud;
      logic [7:0] char_format;
      logic [7:0] flow_opt;
      logic [7:0] special_opt;
      logic [7:0] input_opt;
      logic [7:0] svc_enable;
   } chan_opts_t;

   typedef struct packed {
      logic       parity_en;
      logic       two_stop;
      logic [1:0] char_len;
      logic       inband_flow;
      logic       transp_flow;
      logic       spec1_det;
      logic       spec2_det;
      logic [3:0] rx_thresh;
   } chan_applied_t;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_INIT_CLEAR, ST_INIT_WAIT} cmd_state_t;

endpackage

/* src/chan_cmd_ctrl.sv */
// module: channel command interpreter, global reset sequencer and timer prescaler
`timescale 1ns/1ps
// Contract
// - global reset needs serial channel selected
// - code 81 performs full global reset
// - global reset clears, flushes, disables everything
// - ordinary commands act on selected channel
// - revision cleared first, written last on reset
// - initialisation completes within 500 microseconds
// - tick is clock over 512 over prescale
// - tick drives rx timeouts and delays
// - rx timeout register divides the tick
// - each serial channel has independent settings
// - char format 03 selects 8N1
// - flow option 40 enables inband flow
// - special option 38 transparent, detect, thresh8
// - code 4E applies first three options
// - input option 80 strips high bit
// - service enable 14 enables rx/tx requests; code only stores svc_enable and drives no request output
// - code 1A enables receiver and transmitter
// - clock option 01, period 51 gives 9600; code only stores the clock option and baud registers, with no baud generator
module chan_cmd_ctrl
   import chan_cmd_pkg::*;
#(
   parameter int         NUM_CHAN      = 2,
   parameter int         INIT_CYCLES   = INIT_CLEAR_CYC * 4,
   parameter logic [7:0] FW_REVISION   = 8'hA5 // arbitrary value
)
(
   input  wire logic                  sys_clk,
   input  wire logic                  sys_rst,
   input  wire logic                  clk_en,
   input  wire logic                  reset_n_pin,
   input  wire logic [7:0]            paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   output logic                       timer_tick,
   output logic      [NUM_CHAN-1:0]   rx_timeout_tick,
   output logic      [NUM_CHAN-1:0]   chan_rx_en,
   output logic      [NUM_CHAN-1:0]   chan_tx_en,
   output logic      [NUM_CHAN-1:0]   strip_high_bit,
   output logic      [NUM_CHAN-1:0]   fifo_flush,
   output logic                       core_restart
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0]                 chan_select;
      logic [7:0]                 channel_command_reg;
      logic [7:0]                 firmware_revision_reg;
      logic [7:0]                 timer_prescale_reg;
      cmd_state_t                 state;
      logic [15:0]                init_cnt;
      logic [8:0]                 pre_cnt;
      logic [7:0]                 div_cnt;
      logic                       tick;
      chan_opts_t [NUM_CHAN-1:0]  opts;
      chan_applied_t [NUM_CHAN-1:0] applied;
      logic [NUM_CHAN-1:0]        rx_en;
      logic [NUM_CHAN-1:0]        tx_en;
      logic [NUM_CHAN-1:0]        flush;
      logic [NUM_CHAN-1:0][7:0]   to_cnt;
      logic [NUM_CHAN-1:0]        to_tick;
      logic                       restart;
      logic [31:0]                rdata;
   } ctrl_state_t;

   ctrl_state_t st_reg;
   ctrl_state_t st_next;
   logic        rst_sync1_reg;
   logic        rst_sync2_reg;

   // serial channels occupy select codes 2 and 3; anything else is not serial
   function automatic logic is_serial(input logic [1:0] sel);
      is_serial = (sel == CHAN_SERIAL_A) || (sel == CHAN_SERIAL_B);
   endfunction

   function automatic int chan_idx(input logic [1:0] sel);
      chan_idx = (sel == CHAN_SERIAL_B) ? 1 : 0;
   endfunction

   // ------------------------------------------------------------
   // pin synchroniser for the hardware reset input
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rst_sync1_reg <= 1'b1;
         rst_sync2_reg <= 1'b1;
      end
      else if (clk_en)
      begin
         rst_sync1_reg <= reset_n_pin;
         rst_sync2_reg <= rst_sync1_reg;
      end
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic bus_wr;
   logic bus_rd;
   logic busy;
   int   ci;

   always_comb
   begin
      st_next  = st_reg;
      ci       = chan_idx(st_reg.chan_select);
      busy     = (st_reg.state == ST_INIT_CLEAR) || (st_reg.state == ST_INIT_WAIT);
      bus_wr   = psel && penable && pwrite && !busy;
      // capture in the setup cycle so the registered word stands during the access phase
      bus_rd   = psel && !penable && !pwrite;
      st_next.restart = 1'b0;
      st_next.flush   = '0;
      st_next.tick    = 1'b0;
      st_next.to_tick = '0;

      // tick = clock / 512 / prescale
      if (st_reg.pre_cnt == FIXED_PRESCALE_M1)
      begin
         st_next.pre_cnt = '0;
         if (st_reg.div_cnt + 8'h01 >= st_reg.timer_prescale_reg)
         begin
            st_next.div_cnt = '0;
            st_next.tick    = 1'b1;
         end
         else
            st_next.div_cnt = st_reg.div_cnt + 8'h01;
      end
      else
         st_next.pre_cnt = st_reg.pre_cnt + 9'h001;

      // per-channel timeout dividers run off the tick only
      for (int c = 0; c < NUM_CHAN; c++)
      begin
         if (st_reg.tick)
         begin
            if (st_reg.to_cnt[c] + 8'h01 >= st_reg.opts[c].rx_timeout)
            begin
               st_next.to_cnt[c]  = '0;
               st_next.to_tick[c] = (st_reg.opts[c].rx_timeout != RESET_BYTE);
            end
            else
               st_next.to_cnt[c] = st_reg.to_cnt[c] + 8'h01;
         end
      end

      // register writes; option registers land in the selected serial channel, or in channel 0 when select is not serial
      if (bus_wr)
      begin
         unique case (paddr)
            OFF_CHAN_SELECT: st_next.chan_select = pwdata[1:0];
            OFF_CHAN_CMD:
               if (is_serial(st_reg.chan_select) && st_reg.state == ST_IDLE)
                  st_next.channel_command_reg = pwdata[7:0];
            OFF_FW_REV:      st_next.firmware_revision_reg = pwdata[7:0];
            OFF_PRESCALE:    st_next.timer_prescale_reg    = pwdata[7:0];
            OFF_RX_TIMEOUT:  st_next.opts[ci].rx_timeout   = pwdata[7:0];
            OFF_TX_CLK_OPT:  st_next.opts[ci].tx_clk_opt   = pwdata[7:0];
            OFF_TX_BAUD:     st_next.opts[ci].tx_baud      = pwdata[7:0];
            OFF_RX_CLK_OPT:  st_next.opts[ci].rx_clk_opt   = pwdata[7:0];
            OFF_RX_BAUD:     st_next.opts[ci].rx_baud      = pwdata[7:0];
            OFF_CHAR_FORMAT: st_next.opts[ci].char_format  = pwdata[7:0];
            OFF_FLOW_OPT:    st_next.opts[ci].flow_opt     = pwdata[7:0];
            OFF_SPECIAL_OPT: st_next.opts[ci].special_opt  = pwdata[7:0];
            OFF_INPUT_OPT:   st_next.opts[ci].input_opt    = pwdata[7:0];
            OFF_SVC_ENABLE:  st_next.opts[ci].svc_enable   = pwdata[7:0];
            default: ;
         endcase
      end

      // command execution
      unique case (st_reg.state)
         ST_IDLE:
            if (st_reg.channel_command_reg != CMD_NONE)
               st_next.state = ST_EXEC;
         ST_EXEC:
         begin
            if (st_reg.channel_command_reg == CMD_GLOBAL_RESET)
            begin
               st_next.state    = ST_INIT_CLEAR;
               st_next.init_cnt = '0;
            end
            else
            begin
               if (st_reg.channel_command_reg == CMD_OPTS_CHANGED)
               begin
                  st_next.applied[ci].parity_en   = st_reg.opts[ci].char_format[CHAR_PARITY_BIT];
                  st_next.applied[ci].two_stop    = st_reg.opts[ci].char_format[CHAR_STOP_BIT];
                  st_next.applied[ci].char_len    =
                     st_reg.opts[ci].char_format[CHAR_LEN_LSB +: 2];
                  st_next.applied[ci].inband_flow = st_reg.opts[ci].flow_opt[FLOW_INBAND_BIT];
                  st_next.applied[ci].transp_flow = st_reg.opts[ci].special_opt[SPC_TRANSP_BIT];
                  st_next.applied[ci].spec2_det   = st_reg.opts[ci].special_opt[SPC_DET2_BIT];
                  st_next.applied[ci].spec1_det   = st_reg.opts[ci].special_opt[SPC_DET1_BIT];
                  st_next.applied[ci].rx_thresh   =
                     st_reg.opts[ci].special_opt[SPC_THRESH_LSB +: 4];
               end
               else if (st_reg.channel_command_reg == CMD_RXTX_ENABLE)
               begin
                  st_next.rx_en[ci] = 1'b1;
                  st_next.tx_en[ci] = 1'b1;
               end
               st_next.channel_command_reg = CMD_NONE;
               st_next.state               = ST_IDLE;
            end
         end
         ST_INIT_CLEAR:
         begin
            // revision goes to zero in the same cycle as every other interface register
            st_next.firmware_revision_reg = RESET_BYTE;
            st_next.channel_command_reg   = CMD_NONE;
            st_next.timer_prescale_reg    = RESET_BYTE;
            st_next.chan_select           = '0;
            st_next.opts                  = '0;
            st_next.applied               = '0;
            st_next.rx_en                 = '0;
            st_next.tx_en                 = '0;
            st_next.flush                 = '1;
            st_next.restart               = 1'b1;
            st_next.init_cnt              = st_reg.init_cnt + 16'h0001;
            if (st_reg.init_cnt == 16'(INIT_CLEAR_CYC - 1))
               st_next.state = ST_INIT_WAIT;
         end
         ST_INIT_WAIT:
         begin
            st_next.init_cnt = st_reg.init_cnt + 16'h0001;
            if (st_reg.init_cnt == 16'(INIT_CYCLES - 1))
            begin
               st_next.firmware_revision_reg = FW_REVISION;
               st_next.state                 = ST_IDLE;
            end
         end
      endcase

      // pin reset gives the same sequence as the global reset command
      if (!rst_sync2_reg && st_reg.state != ST_INIT_CLEAR)
      begin
         st_next.state    = ST_INIT_CLEAR;
         st_next.init_cnt = '0;
      end

      st_next.rdata = '0;
      if (bus_rd)
      begin
         unique case (paddr)
            OFF_CHAN_SELECT: st_next.rdata[1:0] = st_reg.chan_select;
            OFF_CHAN_CMD:    st_next.rdata[7:0] = st_reg.channel_command_reg;
            OFF_FW_REV:      st_next.rdata[7:0] = st_reg.firmware_revision_reg;
            OFF_PRESCALE:    st_next.rdata[7:0] = st_reg.timer_prescale_reg;
            OFF_RX_TIMEOUT:  st_next.rdata[7:0] = st_reg.opts[ci].rx_timeout;
            OFF_TX_CLK_OPT:  st_next.rdata[7:0] = st_reg.opts[ci].tx_clk_opt;
            OFF_TX_BAUD:     st_next.rdata[7:0] = st_reg.opts[ci].tx_baud;
            OFF_RX_CLK_OPT:  st_next.rdata[7:0] = st_reg.opts[ci].rx_clk_opt;
            OFF_RX_BAUD:     st_next.rdata[7:0] = st_reg.opts[ci].rx_baud;
            OFF_CHAR_FORMAT: st_next.rdata[7:0] = st_reg.opts[ci].char_format;
            OFF_FLOW_OPT:    st_next.rdata[7:0] = st_reg.opts[ci].flow_opt;
            OFF_SPECIAL_OPT: st_next.rdata[7:0] = st_reg.opts[ci].special_opt;
            OFF_INPUT_OPT:   st_next.rdata[7:0] = st_reg.opts[ci].input_opt;
            OFF_SVC_ENABLE:  st_next.rdata[7:0] = st_reg.opts[ci].svc_enable;
            OFF_CHAN_STATUS: st_next.rdata[3:0] = {st_reg.rx_en, st_reg.tx_en};
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_reg       <= '0;
         st_reg.state <= ST_INIT_CLEAR;
      end
      else if (clk_en)
         st_reg <= st_next;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // zero wait states: option words are captured in the setup cycle, the rest read live
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   always_comb
   begin
      prdata = '0;
      unique case (paddr)
         OFF_CHAN_SELECT: prdata[1:0] = st_reg.chan_select;
         OFF_CHAN_CMD:    prdata[7:0] = st_reg.channel_command_reg;
         OFF_FW_REV:      prdata[7:0] = st_reg.firmware_revision_reg;
         OFF_PRESCALE:    prdata[7:0] = st_reg.timer_prescale_reg;
         OFF_CHAN_STATUS: prdata[3:0] = {st_reg.rx_en, st_reg.tx_en};
         default:         prdata      = st_reg.rdata;
      endcase
   end

   assign timer_tick      = st_reg.tick;
   assign rx_timeout_tick = st_reg.to_tick;
   assign chan_rx_en      = st_reg.rx_en;
   assign chan_tx_en      = st_reg.tx_en;
   assign fifo_flush      = st_reg.flush;
   assign core_restart    = st_reg.restart;
   always_comb
   begin
      for (int c = 0; c < NUM_CHAN; c++)
         strip_high_bit[c] = st_reg.opts[c].input_opt[STRIP_BIT];
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   cmd_clears_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clk_en && st_reg.state == ST_EXEC && st_reg.channel_command_reg != CMD_GLOBAL_RESET)
      |=> st_reg.channel_command_reg == CMD_NONE || !$past(clk_en))
      else $error("command register not cleared after command");
   rev_zero_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clk_en && st_reg.state == ST_INIT_CLEAR) |=> st_reg.firmware_revision_reg == RESET_BYTE)
      else $error("revision not cleared during init");
   init_done_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (st_reg.state == ST_INIT_WAIT) |-> st_reg.init_cnt < 16'(INIT_CYCLES))
      else $error("init ran past its limit");
   rxtx_enable_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clk_en && st_reg.state == ST_EXEC && st_reg.channel_command_reg == CMD_RXTX_ENABLE
       && rst_sync2_reg) |=> st_reg.rx_en[$past(ci)] && st_reg.tx_en[$past(ci)])
      else $error("rx/tx not enabled by command");
   reset_disables_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clk_en && st_reg.state == ST_INIT_CLEAR) |=> st_reg.rx_en == '0 && st_reg.opts == '0)
      else $error("global reset left channels enabled");
   tick_spacing_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (st_reg.tick && clk_en) |=> !st_reg.tick)
      else $error("timer tick not divided");
   global_cmd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clk_en && st_reg.state == ST_EXEC && st_reg.channel_command_reg == CMD_GLOBAL_RESET)
      |=> st_reg.state == ST_INIT_CLEAR)
      else $error("global reset command not started");
   sel_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clk_en && bus_wr && paddr == OFF_CHAN_CMD && !is_serial(st_reg.chan_select)
       && st_reg.channel_command_reg == CMD_NONE && st_reg.state == ST_IDLE && rst_sync2_reg)
      |=> st_reg.channel_command_reg == CMD_NONE)
      else $error("command accepted with parallel channel selected");

endmodule

/* verification/apb_host_model.sv */
// host-side driver model: apb master transfers and polling loops
`timescale 1ns/1ps
module apb_host_model
(
   input  wire logic        sys_clk,
   output logic [7:0]       paddr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready
);
   initial
   begin
      paddr = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0000_0000;
   end

   // -----------------------------------------------
   // one transfer; request held until pready is sampled high at a clock edge
   // -----------------------------------------------
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 32);
      if (n >= 32)
         tb_channel_command_reset_init.hang("apb answer");
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // released data lines show the inverse so stale values never pass
      pwdata <= ~d;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0000_0000, q);
   endtask

   // a command may only follow once the command register reads zero
   task automatic wait_cmd_zero();
      logic [31:0] q;
      int n;
      n = 0;
      do
      begin
         rd(8'h04, q);
         n++;
      end
      while (q !== 32'h0000_0000 && n < 64);
      if (n >= 64)
         tb_channel_command_reset_init.hang("command clear");
   endtask

   // bound: 500 us at 125 MHz, three cycles per read
   task automatic wait_rev(output logic [31:0] q);
      int n;
      n = 0;
      do
      begin
         rd(8'h08, q);
         n++;
      end
      while ((q === 32'h0000_0000 || $isunknown(q)) && n < 21000);
      if (n >= 21000)
         tb_channel_command_reset_init.hang("revision");
   endtask
endmodule

/* verification/tb_channel_command_reset_init.sv */
// testbench: command handshake, global and pin reset, timer tick, channel setup
`timescale 1ns/1ps
module tb_channel_command_reset_init;
   import chan_cmd_pkg::*;
   localparam logic [7:0] REV = 8'h5C; // arbitrary value
   logic sys_clk, sys_rst, clk_en, reset_n_pin, psel, penable, pwrite, pready, pslverr;
   logic timer_tick, core_restart;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [1:0]  rx_timeout_tick, chan_rx_en, chan_tx_en, strip_high_bit, fifo_flush;
   int bad_count = 0;
   int n_checks = 0;
   logic [7:0] oa [8] = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
   logic [7:0] ov [8] = '{8'h14, 8'h01, 8'h51, 8'h01, 8'h51, 8'h03, 8'h40, 8'h38};

   chan_cmd_ctrl #(.FW_REVISION(REV)) u_chan_cmd_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .clk_en(clk_en), .reset_n_pin(reset_n_pin), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_tick(timer_tick), .rx_timeout_tick(rx_timeout_tick),
      .chan_rx_en(chan_rx_en), .chan_tx_en(chan_tx_en), .strip_high_bit(strip_high_bit),
      .fifo_flush(fifo_flush), .core_restart(core_restart));
   apb_host_model u_apb_host_model (.sys_clk(sys_clk), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready));

   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic hang(input string what);
      bad_count++;
      $display("[ERR] %0t wait for %s ran out", $time, what);
      wrap_up();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // cycles until the chosen output is sampled high; 0 tick, 1 rx timeout, 2 flush
   task automatic wait_hi(input int sel, input int lim, output int n);
      logic v;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
         v = (sel == 0) ? timer_tick : (sel == 1) ? rx_timeout_tick[0] : fifo_flush[0];
      end
      while (v !== 1'b1 && n < lim);
      if (n >= lim)
         hang("output pulse");
   endtask

   task automatic t_refuse();
      u_apb_host_model.wr(8'h00, 32'h0000_0001);
      u_apb_host_model.wr(8'h04, 32'h0000_001A);
      u_apb_host_model.rd(8'h04, q);
      chk(q, 32'h0, "parallel command");
      chk({30'h0, chan_rx_en}, 32'h0, "parallel enable");
      u_apb_host_model.rd(8'h3C, q);
      chk(q, 32'h0, "unmapped read");
      chk({31'h0, pslverr}, 32'h0, "no slave error");
   endtask

   task automatic t_config();
      u_apb_host_model.wr(8'h00, 32'h0000_0002);
      foreach (oa[i]) u_apb_host_model.wr(oa[i], {24'h0, ov[i]});
      u_apb_host_model.wait_cmd_zero();
      u_apb_host_model.wr(8'h04, 32'h0000_004E);
      u_apb_host_model.wr(8'h30, 32'h0000_0080);
      u_apb_host_model.wr(8'h34, 32'h0000_0014);
      u_apb_host_model.wait_cmd_zero();
      u_apb_host_model.wr(8'h04, 32'h0000_001A);
      u_apb_host_model.wait_cmd_zero();
      chk({28'h0, chan_rx_en, chan_tx_en}, 32'h5, "enables");
      chk({30'h0, strip_high_bit}, 32'h1, "strip");
      foreach (oa[i])
      begin
         u_apb_host_model.rd(oa[i], q);
         chk(q, {24'h0, ov[i]}, "option readback");
      end
      u_apb_host_model.wr(8'h00, 32'h0000_0003);
      u_apb_host_model.rd(8'h24, q);
      chk(q, 32'h0, "other channel untouched");
   endtask

   task automatic t_timer();
      int n;
      u_apb_host_model.wr(8'h0C, 32'h0000_0031);
      u_apb_host_model.rd(8'h0C, q);
      chk(q, 32'h0000_0031, "prescale readback");
      // short divisors below keep the run brief; the measured periods scale the same way
      u_apb_host_model.wr(8'h0C, 32'h0000_0002);
      wait_hi(0, 4000, n);
      wait_hi(0, 4000, n);
      chk(n, 32'd1024, "tick period");
      u_apb_host_model.wr(8'h0C, 32'h0000_0001);
      wait_hi(1, 30000, n);
      wait_hi(1, 30000, n);
      chk(n, 32'd10240, "rx timeout period");
      // clock enable low must freeze the divider, so no tick may appear
      clk_en <= 1'b0;
      n = 0;
      repeat (600)
      begin
         @(posedge sys_clk);
         n += timer_tick;
      end
      clk_en <= 1'b1;
      chk(n, 32'h0, "frozen by clock enable");
   endtask

   task automatic t_reset(input logic by_pin);
      int n;
      if (by_pin)
      begin
         reset_n_pin <= 1'b0;
         repeat (6) @(posedge sys_clk);
         reset_n_pin <= 1'b1;
      end
      else
      begin
         u_apb_host_model.wr(8'h08, 32'h0);
         u_apb_host_model.wait_cmd_zero();
         u_apb_host_model.wr(8'h04, {24'h0, CMD_GLOBAL_RESET});
      end
      wait_hi(2, 40, n);
      chk({29'h0, fifo_flush, core_restart}, 32'h7, "flush and restart");
      u_apb_host_model.rd(8'h08, q);
      chk(q, 32'h0, "revision cleared first");
      u_apb_host_model.wait_rev(q);
      chk(q, {24'h0, REV}, "revision last");
      chk({26'h0, chan_rx_en, chan_tx_en, strip_high_bit}, 32'h0, "channels off");
      u_apb_host_model.rd(8'h0C, q);
      chk(q, 32'h0, "prescale cleared");
      u_apb_host_model.rd(8'h00, q);
      chk(q, 32'h0, "select cleared");
   endtask

   initial
   begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      reset_n_pin = 1'b1;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      u_apb_host_model.wait_rev(q);
      chk(q, {24'h0, REV}, "boot revision");
      t_refuse();
      t_config();
      t_timer();
      t_reset(1'b0);
      t_config();
      t_reset(1'b1);
      wrap_up();
   end
endmodule
